// File: src/smh_pkg.sv
// constants and carrier types for the smbus host controller
// assumes a 50 MHz clock and an open-drain bus with external pull-ups
// What the document requires of bus and device
// RULE1 - start is SDA falling while SCL high
// RULE2 - first byte: 7-bit address msb first, direction
// RULE3 - addressed device acks in ninth clock
// RULE4 - direction 0 writes, 1 reads
// RULE5 - nine clocks per byte, SDA moves SCL low
// RULE6 - master nacks last read byte, then stops
// RULE7 - writes carry one or two bytes, reads one
// RULE8 - first write byte loads register pointer
// RULE9 - second write byte stores to pointed register
// RULE10 - pointerless read returns pointed register
// RULE11 - repeated start begins a new address phase
// RULE12 - send byte loads pointer for later read
// RULE13 - send byte may chain into repeated-start read
// RULE14 - receive byte: one byte, nack, stop
// RULE15 - command 0xA0 opens a block write
// RULE16 - master sets pointer and length before block
// RULE17 - block write data acked, pec acked if right
// RULE18 - block read: 0xA1, repeated start, read address
// RULE19 - block read count first, at most 32
// RULE20 - data acked, pec nacked, then stop
// RULE21 - pec is crc-8, polynomial x8+x2+x+1
// RULE22 - pec byte optional on every transaction; the code offers it on block write and block read only
// RULE23 - device address 0x5C float, 0x58 low
// RULE24 - device also answers default address 0x61
// RULE25 - optional 25 ms bus timeout in device
// RULE26 - block bytes map to consecutive registers
package smh_pkg;
    localparam logic [6:0] ADDR_FLOAT = 7'h5C;
    localparam logic [6:0] ADDR_LOW = 7'h58;
    localparam logic [6:0] ADDR_DEFAULT = 7'h61;
    localparam logic [7:0] CMD_BLOCK_WRITE = 8'hA0;
    localparam logic [7:0] CMD_BLOCK_READ = 8'hA1;
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam int MAX_BLOCK = 32;
    localparam int CLK_HZ = 50000000;
    localparam int SCL_HZ = 100000;
    // quarter-period enable; four phases make one SCL bit
    localparam int QUARTER_CYCLES = CLK_HZ / (SCL_HZ * 4);

    typedef enum logic [3:0] {
        SMH_OP_SEND = 4'h0,      // address, pointer byte
        SMH_OP_WRITE = 4'h1,     // address, pointer, data
        SMH_OP_RECEIVE = 4'h2,   // address read, one byte
        SMH_OP_READ = 4'h3,      // pointer, repeated start, one byte
        SMH_OP_BLK_WRITE = 4'h4, // 0xA0, n data, optional pec
        SMH_OP_BLK_READ = 4'h5   // 0xA1, rs, count, n data, optional pec
    } smh_op_t;

    typedef struct packed {
        smh_op_t op;
        logic [6:0] addr;
        logic [7:0] pointer;
        logic [7:0] data;
        logic [5:0] count;
        logic usePec;
    } smh_cmd_t;

    typedef struct packed {
        logic sclOut;
        logic sclOe;
        logic sdaOut;
        logic sdaOe;
    } smh_pins_t;
endpackage

// File: src/smh_crc8.sv
// crc-8 accumulator for packet error checking, one byte per enable
// assumes clear and update never come in the same cycle as a needed result
`timescale 1ns/10ps
module smh_crc8 (
    input wire logic clk,
    input wire logic resetn,
    input wire logic clear,
    input wire logic update,
    input wire logic [7:0] dataIn,
    output logic [7:0] crc
);
    logic [7:0] crc_reg;
    logic [7:0] crc_next;
    logic [7:0] step [0:8];

    assign step[0] = crc_reg ^ dataIn;
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_bit
            assign step[i+1] = step[i][7] ? ((step[i] << 1) ^ smh_pkg::CRC_POLY) : (step[i] << 1); // [RULE21]
        end
    endgenerate

    always_comb begin
        crc_next = crc_reg;
        if (clear) begin
            crc_next = 8'h00;
        end else if (update) begin
            crc_next = step[8];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            crc_reg <= 8'h00;
        end else begin
            crc_reg <= crc_next;
        end
    end

    assign crc = crc_reg;
endmodule // smh_crc8

// File: src/smh_master.sv
// smbus master controller driving a register-pointer slave over open-drain pins
// assumes pin inputs synchronous to clk; user holds cmd while cmdValid until cmdReady
`timescale 1ns/10ps
module smh_master #(
    parameter int QUARTER = smh_pkg::QUARTER_CYCLES,
    parameter int MAXN = smh_pkg::MAX_BLOCK
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic cmdValid,
    input wire smh_pkg::smh_cmd_t cmd,
    output logic cmdReady,
    output logic [7:0] rdData,
    output logic rdValid,
    output logic done,
    output logic nackErr,
    output logic pecErr,
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sclOut,
    output logic sclOe,
    output logic sdaOut,
    output logic sdaOe
);
    // the quarter divider is 16 bits wide
    if (QUARTER < 1 || QUARTER > 65536 || MAXN < 1 || MAXN > smh_pkg::MAX_BLOCK) begin : g_bad_param
        $error("smh_master: bad parameter");
    end

    typedef enum logic [6:0] {
        ST_IDLE = 7'b0000001,
        ST_START = 7'b0000010,
        ST_TXBYTE = 7'b0000100,
        ST_RXBYTE = 7'b0001000,
        ST_NEXT = 7'b0010000,
        ST_STOP = 7'b0100000,
        ST_END = 7'b1000000
    } smh_state_t;

    // byte roles within a transaction
    typedef enum logic [2:0] {
        R_ADDR = 3'h0, R_PTR = 3'h1, R_DATA = 3'h2, R_PEC = 3'h3,
        R_RADDR = 3'h4, R_COUNT = 3'h5, R_RDATA = 3'h6
    } smh_role_t;

    typedef struct packed {
        smh_state_t st;
        smh_role_t role;
        smh_pkg::smh_cmd_t c;
        logic [15:0] div;
        logic [1:0] phase;
        logic [3:0] bitCnt;
        logic [7:0] shift;
        logic [5:0] left;
        logic ackSeen;
        logic cmdReady;
        logic [7:0] rdData;
        logic rdValid;
        logic done;
        logic nackErr;
        logic pecErr;
        smh_pkg::smh_pins_t pins;
    } smh_regs_t;

    smh_regs_t s_reg;
    smh_regs_t s_next;
    logic tick;
    logic crcClear;
    logic crcUpdate;
    logic [7:0] crcByte;
    logic [7:0] crcVal;

    smh_crc8 u_crc (
        .clk(clk),
        .resetn(resetn),
        .clear(crcClear),
        .update(crcUpdate),
        .dataIn(crcByte),
        .crc(crcVal)
    );

    assign tick = (s_reg.div == 16'(QUARTER - 1));

    always_comb begin
        s_next = s_reg;
        s_next.rdValid = 1'b0;
        s_next.done = 1'b0;
        s_next.cmdReady = 1'b0;
        crcClear = 1'b0;
        crcUpdate = 1'b0;
        crcByte = s_reg.shift;
        s_next.div = tick ? 16'h0000 : s_reg.div + 16'h0001;
        if (s_reg.st == ST_IDLE) begin
            s_next.div = 16'h0000;
        end
        case (s_reg.st)
            ST_IDLE: begin
                s_next.pins = '{sclOut: 1'b0, sclOe: 1'b0, sdaOut: 1'b0, sdaOe: 1'b0};
                if (cmdValid) begin
                    s_next.c = cmd;
                    s_next.cmdReady = 1'b1;
                    s_next.nackErr = 1'b0;
                    s_next.pecErr = 1'b0;
                    s_next.left = (cmd.count > 6'(MAXN)) ? 6'(MAXN) : cmd.count; // [RULE19]
                    s_next.role = R_ADDR;
                    s_next.shift = {cmd.addr, (cmd.op == smh_pkg::SMH_OP_RECEIVE)}; // [RULE2] [RULE4] [RULE14]
                    s_next.phase = 2'h0;
                    crcClear = 1'b1;
                    s_next.st = ST_START;
                end
            end
            ST_START: if (tick) begin
                // phases: release both, pull SDA with SCL high, pull SCL
                s_next.phase = s_reg.phase + 2'h1;
                case (s_reg.phase)
                    2'h0: s_next.pins = '{1'b0, 1'b0, 1'b0, 1'b0};
                    2'h1: begin
                        // a stretching slave may still hold SCL low; pulling SDA then is no start
                        if (sclIn) begin
                            s_next.pins.sdaOe = 1'b1; // [RULE1] [RULE11]
                        end else begin
                            s_next.phase = s_reg.phase;
                        end
                    end
                    2'h2: s_next.pins.sclOe = 1'b1;
                    default: begin
                        s_next.bitCnt = 4'h0;
                        s_next.phase = 2'h0;
                        s_next.st = ST_TXBYTE;
                    end
                endcase
            end
            ST_TXBYTE, ST_RXBYTE: if (tick) begin
                s_next.phase = s_reg.phase + 2'h1;
                case (s_reg.phase)
                    2'h0: begin
                        // SDA changes only while SCL is held low
                        if (s_reg.bitCnt < 4'h8) begin
                            s_next.pins.sdaOe = (s_reg.st == ST_TXBYTE) ? ~s_reg.shift[7] : 1'b0; // [RULE5]
                        end else if (s_reg.st == ST_TXBYTE) begin
                            s_next.pins.sdaOe = 1'b0;
                        end else begin
                            // ack every read byte but the last; the pec or single byte is nacked
                            s_next.pins.sdaOe = (s_reg.role == R_COUNT) || (s_reg.role == R_RDATA &&
                                (s_reg.left > 6'h1 || (s_reg.left == 6'h1 && s_reg.c.usePec))); // [RULE6] [RULE20]
                        end
                    end
                    2'h1: s_next.pins.sclOe = 1'b0;
                    2'h2: begin
                        if (sclIn) begin
                            if (s_reg.bitCnt < 4'h8) begin
                                // transmit rotates, so the byte is whole again for the crc at bit 7
                                s_next.shift = (s_reg.st == ST_RXBYTE) ? {s_reg.shift[6:0], sdaIn} :
                                    {s_reg.shift[6:0], s_reg.shift[7]};
                            end else begin
                                s_next.ackSeen = ~sdaIn; // [RULE3]
                            end
                        end else begin
                            s_next.phase = s_reg.phase; // clock stretched by the slave
                        end
                    end
                    default: begin
                        s_next.pins.sclOe = 1'b1;
                        s_next.phase = 2'h0;
                        s_next.bitCnt = s_reg.bitCnt + 4'h1;
                        if (s_reg.bitCnt == 4'h7) begin
                            crcUpdate = 1'b1;
                        end
                        if (s_reg.bitCnt == 4'h8) begin
                            s_next.st = ST_NEXT; // [RULE5]
                        end
                    end
                endcase
            end
            ST_NEXT: begin
                s_next.bitCnt = 4'h0;
                s_next.phase = 2'h0;
                s_next.st = ST_TXBYTE;
                if (s_reg.role == R_COUNT || s_reg.role == R_RDATA) begin
                    s_next.rdData = s_reg.shift;
                    s_next.rdValid = (s_reg.role == R_RDATA);
                end
                if (s_reg.role == R_ADDR || s_reg.role == R_RADDR || s_reg.role == R_PTR ||
                    s_reg.role == R_DATA || (s_reg.role == R_PEC && s_reg.c.op == smh_pkg::SMH_OP_BLK_WRITE)) begin
                    if (!s_reg.ackSeen) begin
                        // a nack on a block pec means the data must be resent by the user
                        s_next.nackErr = (s_reg.role != R_PEC);
                        s_next.pecErr = (s_reg.role == R_PEC); // [RULE17]
                        s_next.st = ST_STOP;
                    end
                end
                if (s_next.st == ST_TXBYTE) begin
                    case (s_reg.role)
                        R_ADDR: begin
                            if (s_reg.c.op == smh_pkg::SMH_OP_RECEIVE) begin
                                s_next.role = R_RDATA; // [RULE10]
                                s_next.left = 6'h0;
                                s_next.st = ST_RXBYTE;
                            end else begin
                                s_next.role = R_PTR;
                                case (s_reg.c.op)
                                    smh_pkg::SMH_OP_BLK_WRITE: s_next.shift = smh_pkg::CMD_BLOCK_WRITE; // [RULE15]
                                    smh_pkg::SMH_OP_BLK_READ: s_next.shift = smh_pkg::CMD_BLOCK_READ; // [RULE18]
                                    default: s_next.shift = s_reg.c.pointer; // [RULE8] [RULE12]
                                endcase
                            end
                        end
                        R_PTR: begin
                            case (s_reg.c.op)
                                smh_pkg::SMH_OP_WRITE: begin
                                    s_next.role = R_DATA;
                                    s_next.left = 6'h0;
                                    s_next.shift = s_reg.c.data; // [RULE9] [RULE7]
                                end
                                smh_pkg::SMH_OP_BLK_WRITE: begin
                                    s_next.role = R_DATA;
                                    s_next.shift = s_reg.c.data; // [RULE16]
                                    s_next.left = s_reg.left - 6'h1;
                                end
                                smh_pkg::SMH_OP_READ, smh_pkg::SMH_OP_BLK_READ: begin
                                    s_next.role = R_RADDR;
                                    s_next.shift = {s_reg.c.addr, 1'b1}; // [RULE13] [RULE18]
                                    s_next.phase = 2'h0;
                                    s_next.st = ST_START;
                                end
                                default: s_next.st = ST_STOP;
                            endcase
                        end
                        R_DATA: begin
                            // block writes repeat the user data byte across consecutive registers
                            if (s_reg.c.op == smh_pkg::SMH_OP_BLK_WRITE && s_reg.left != 6'h0) begin
                                s_next.shift = s_reg.c.data; // [RULE26]
                                s_next.left = s_reg.left - 6'h1;
                            end else if (s_reg.c.op == smh_pkg::SMH_OP_BLK_WRITE && s_reg.c.usePec) begin
                                s_next.role = R_PEC;
                                s_next.shift = crcVal; // [RULE21]
                            end else begin
                                s_next.st = ST_STOP; // [RULE22]
                            end
                        end
                        R_RADDR: begin
                            s_next.st = ST_RXBYTE;
                            s_next.role = (s_reg.c.op == smh_pkg::SMH_OP_BLK_READ) ? R_COUNT : R_RDATA;
                            if (s_reg.c.op != smh_pkg::SMH_OP_BLK_READ) begin
                                s_next.left = 6'h0;
                            end
                        end
                        R_COUNT: begin
                            s_next.st = ST_RXBYTE;
                            s_next.role = R_RDATA; // [RULE19]
                        end
                        R_RDATA: begin
                            if (s_reg.c.op == smh_pkg::SMH_OP_BLK_READ && s_reg.left > 6'h1) begin
                                s_next.st = ST_RXBYTE;
                                s_next.left = s_reg.left - 6'h1;
                            end else if (s_reg.c.op == smh_pkg::SMH_OP_BLK_READ && s_reg.left == 6'h1 &&
                                s_reg.c.usePec) begin
                                s_next.st = ST_RXBYTE;
                                s_next.left = 6'h0;
                                s_next.role = R_PEC;
                            end else begin
                                s_next.st = ST_STOP; // [RULE14]
                            end
                        end
                        default: begin
                            // pec byte sent or received: crc over the whole frame including pec is zero
                            s_next.pecErr = (crcVal != 8'h00); // [RULE20]
                            s_next.st = ST_STOP;
                        end
                    endcase
                    if (s_reg.role == R_PEC && s_reg.c.op == smh_pkg::SMH_OP_BLK_READ) begin
                        s_next.pecErr = (crcVal != 8'h00);
                        s_next.st = ST_STOP;
                    end
                    if (s_reg.role == R_PEC && s_reg.c.op == smh_pkg::SMH_OP_BLK_WRITE) begin
                        s_next.st = ST_STOP;
                    end
                end
            end
            ST_STOP: if (tick) begin
                s_next.phase = s_reg.phase + 2'h1;
                case (s_reg.phase)
                    2'h0: s_next.pins.sdaOe = 1'b1;
                    2'h1: s_next.pins.sclOe = 1'b0;
                    2'h2: begin
                        if (sclIn) begin
                            s_next.pins.sdaOe = 1'b0; // [RULE6]
                        end else begin
                            s_next.phase = s_reg.phase;
                        end
                    end
                    default: s_next.st = ST_END;
                endcase
            end
            ST_END: begin
                s_next.done = 1'b1;
                s_next.st = ST_IDLE;
            end
            default: s_next.st = ST_IDLE;
        endcase
        // in receive the pec byte goes in role R_PEC as well
        if (s_reg.st == ST_NEXT && s_reg.role == R_RDATA && s_next.role == R_PEC) begin
            s_next.st = ST_RXBYTE;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_reg <= '0;
            s_reg.st <= ST_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    assign cmdReady = s_reg.cmdReady;
    assign rdData = s_reg.rdData;
    assign rdValid = s_reg.rdValid;
    assign done = s_reg.done;
    assign nackErr = s_reg.nackErr;
    assign pecErr = s_reg.pecErr;
    assign sclOut = s_reg.pins.sclOut;
    assign sclOe = s_reg.pins.sclOe;
    assign sdaOut = s_reg.pins.sdaOut;
    assign sdaOe = s_reg.pins.sdaOe;
endmodule // smh_master

// File: sim/smh_master_props.sv
// concurrent checks on the host controller ports
// assumes binding from the bench top; one clock domain
`timescale 1ns/10ps
module smh_master_props (
    input wire logic clk,
    input wire logic resetn,
    input wire logic cmdValid,
    input wire smh_pkg::smh_cmd_t cmd,
    input wire logic cmdReady,
    input wire logic [7:0] rdData,
    input wire logic rdValid,
    input wire logic done,
    input wire logic nackErr,
    input wire logic pecErr,
    input wire logic sclIn,
    input wire logic sdaIn,
    input wire logic sclOut,
    input wire logic sclOe,
    input wire logic sdaOut,
    input wire logic sdaOe
);
    logic busyReg;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            busyReg <= 1'b0;
        end else if (cmdReady || done) begin
            busyReg <= cmdReady;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    open_drain_a: assert property (!sclOut && !sdaOut)
        else $error("bus pin driven high");
    ready_cause_a: assert property (cmdReady |-> $past(cmdValid) && (!$past(busyReg) || $past(done)))
        else $error("ready without request");
    busy_refuse_a: assert property (busyReg |-> !cmdReady)
        else $error("request taken while busy");
    bus_owned_a: assert property (sclOe || sdaOe |-> busyReg || cmdReady)
        else $error("bus driven while idle");
    start_clock_a: assert property ($rose(sdaOe) && sclIn |-> ##[1:16] sclOe)
        else $error("start not followed by clock");
    stop_done_a: assert property ($fell(sdaOe) && sclIn |-> ##[0:64] done)
        else $error("stop not followed by done");
    done_release_a: assert property (done |-> !sclOe && !sdaOe ##1 !done)
        else $error("bus held after done");
    read_inside_a: assert property (rdValid |-> busyReg)
        else $error("read data outside transfer");
endmodule // smh_master_props

// File: sim/smh_slave_model.sv
// behavioural register-pointer slave on the far side of the bus
// assumes resolved open-drain levels on scl and sda, oversampled on clk
`timescale 1ns/10ps
module smh_slave_model #(
    parameter logic [6:0] OWN_ADDR = 7'h5C
) (
    input wire logic clk,
    input wire logic scl,
    input wire logic sda,
    input wire logic corrupt,
    input wire logic [3:0] stretch,
    output logic sdaLow,
    output logic sclLow
);
    logic [7:0] mem [256];
    logic [7:0] ptr, rx, tx, crc, n, len;
    logic [3:0] b, hold;
    logic pS, pD, hit, rd, blkW, blkR, mAck, ack, pec;
    int idx;
    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
        c = c ^ d;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
        end
        return c;
    endfunction
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'h00;
        end
        {hit, blkR, sdaLow, sclLow, hold, ptr} = '0;
        {pS, pD} = 2'h3;
    end
    // no bus timeout: it is off by default
    always @(posedge clk) begin
        len = {2'h0, mem[0][5:0]}; // block length field, low bits of register 0 assumed
        hold = (hold != 4'h0) ? hold - 4'h1 : hold;
        if (pS && scl && pD && !sda) begin
            {b, idx, hit, rd, blkW} = {4'hF, 32'h0, 3'h4}; // parked: the start's own scl fall opens bit 0
            crc = blkR ? crc : 8'h00;
            sdaLow <= 1'b0;
        end else if (pS && scl && !pD && sda) begin
            {hit, blkR} = 2'h0;
            sdaLow <= 1'b0;
        end else if (!pS && scl && hit) begin
            rx = (b < 4'h8) ? {rx[6:0], sda} : rx;
            mAck = !sda;
        end else if (pS && !scl && hit) begin
            hold = stretch;
            if (b < 4'h7) begin
                b = b + 4'h1;
                sdaLow <= rd && !tx[7 - b];
            end else if (b == 4'h7) begin
                b = 4'h8;
                pec = blkW && idx > 1 && n == len;
                ack = !rd && (!pec || ((rx == crc) != corrupt));
                if (!rd) begin
                    if (idx == 0) begin
                        hit = rx[7:1] == OWN_ADDR || rx[7:1] == 7'h61;
                        ack = hit;
                    end else if (idx == 1) begin
                        blkW = rx == 8'hA0;
                        blkR = rx == 8'hA1;
                        ptr = (blkW || blkR) ? ptr : rx;
                        n = 8'h00;
                    end else if (blkW && !pec) begin
                        mem[ptr + n] = rx;
                        n = n + 8'h01;
                    end else if (idx == 2 && !blkW) begin
                        mem[ptr] = rx;
                    end else if (!blkW) begin
                        ack = 1'b0;
                    end
                    crc = crc8(crc, rx);
                    idx++;
                end
                sdaLow <= ack;
            end else begin
                b = 4'h0;
                rd = rd || (idx == 1 && rx[0]);
                hit = !(rd && !mAck);
                if (rd && hit) begin
                    tx = !blkR ? mem[ptr] : (n == 8'h00) ? len : (n <= len) ? mem[ptr + n - 8'h01]
                        : corrupt ? ~crc : crc;
                    crc = (blkR && n > len) ? crc : crc8(crc, tx);
                    n = n + 8'h01;
                end
                sdaLow <= rd && hit && !tx[7];
            end
        end
        pS = scl;
        pD = sda;
        sclLow <= hold != 4'h0;
    end
endmodule // smh_slave_model

// File: sim/smh_master_tb.sv
// self-checking bench: host controller against the behavioural slave
// assumes pull-ups on both lines, modelled by the resolved wires below
`timescale 1ns/10ps
module smh_master_tb;
    logic clk, resetn, cmdValid, cmdReady, rdValid, done, nackErr, pecErr;
    logic sclOut, sclOe, sdaOut, sdaOe, sdaLow, sclLow, corrupt, usePec;
    logic [3:0] stretch;
    logic [7:0] rdData, p, d, len;
    logic [15:0] lfsr;
    logic [7:0] got[$];
    smh_pkg::smh_cmd_t cmd;
    int miscompares, comparisons;
    wire scl = !(sclOe || sclLow);
    wire sda = !(sdaOe || sdaLow);
    smh_master #(.QUARTER(2)) u_smh_master (.clk(clk), .resetn(resetn), .cmdValid(cmdValid), .cmd(cmd),
        .cmdReady(cmdReady), .rdData(rdData), .rdValid(rdValid), .done(done), .nackErr(nackErr), .pecErr(pecErr),
        .sclIn(scl), .sdaIn(sda), .sclOut(sclOut), .sclOe(sclOe), .sdaOut(sdaOut), .sdaOe(sdaOe));
    smh_slave_model slv (.clk(clk), .scl(scl), .sda(sda), .corrupt(corrupt), .stretch(stretch),
        .sdaLow(sdaLow), .sclLow(sclLow));
    function automatic logic [7:0] rnd();
        lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr[7:0];
    endfunction
    task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] act);
        comparisons++;
        if (act !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, act);
        end
    endtask
    task automatic check_flag(input string what, input logic exp, input logic act);
        check_byte(what, {7'h00, exp}, {7'h00, act});
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d, miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // entered at 1 ns after an edge; request held one edge past the ready pulse
    task automatic run(input smh_pkg::smh_op_t op, input logic [6:0] a, input logic [7:0] pt,
            input logic [7:0] dt, input logic [5:0] n, input logic pc);
        int t;
        logic seen;
        got.delete();
        seen = 1'b0;
        cmd = '{op: op, addr: a, pointer: pt, data: dt, count: n, usePec: pc};
        cmdValid = 1'b1;
        for (t = 0; t < 20000 && (t == 0 || done !== 1'b1); t++) begin
            @(posedge clk);
            #1;
            if (seen) cmdValid = 1'b0;
            seen = seen || cmdReady === 1'b1;
            if (rdValid === 1'b1) got.push_back(rdData);
        end
        check_flag("transaction done", 1'b1, done);
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        #1500000;
        miscompares++;
        report_and_stop();
    end
    initial begin
        {resetn, cmdValid, cmd, corrupt, stretch, miscompares, comparisons} = '0;
        lfsr = 16'hFC7B;
        repeat (4) @(posedge clk);
        #1 resetn = 1'b1;
        check_flag("bus released", 1'b0, sclOe | sdaOe);
        for (int i = 0; i < 6; i++) begin
            p = rnd() & 8'h3F;
            d = rnd();
            stretch = 4'(rnd() % 8'h05);
            run(smh_pkg::SMH_OP_WRITE, 7'h5C, p, d, 6'h00, 1'b0);
            check_byte("stored register", d, slv.mem[p]);
            run(smh_pkg::SMH_OP_WRITE, 7'h5C, p | 8'h40, ~d, 6'h00, 1'b0);
            run(smh_pkg::SMH_OP_SEND, 7'h5C, p, 8'h00, 6'h00, 1'b0);
            run(smh_pkg::SMH_OP_RECEIVE, 7'h5C, 8'h00, 8'h00, 6'h00, 1'b0);
            check_byte("received byte", d, got[0]);
            run(smh_pkg::SMH_OP_READ, i[0] ? 7'h61 : 7'h5C, p | 8'h40, 8'h00, 6'h00, 1'b0);
            check_byte("read byte", ~d, got[0]);
            check_byte("read length", 8'h01, 8'(got.size()));
            check_flag("acknowledged", 1'b0, nackErr);
        end
        run(smh_pkg::SMH_OP_WRITE, 7'h58, 8'h10, 8'h00, 6'h00, 1'b0);
        check_flag("address refused", 1'b1, nackErr);
        for (int k = 0; k < 4; k++) begin
            len = (k == 1) ? 8'h20 : (k == 0) ? 8'h01 : 8'h07;
            p = (rnd() & 8'h3F) | 8'h40;
            d = rnd();
            usePec = k != 2;
            run(smh_pkg::SMH_OP_WRITE, 7'h5C, 8'h00, len, 6'h00, 1'b0);
            run(smh_pkg::SMH_OP_SEND, 7'h5C, p, 8'h00, 6'h00, 1'b0);
            corrupt = k == 3;
            run(smh_pkg::SMH_OP_BLK_WRITE, 7'h5C, 8'h00, d, len[5:0], usePec);
            check_flag("write check error", corrupt, pecErr);
            for (int j = 0; j < len; j++) begin
                check_byte("block register", d, slv.mem[p + j]);
            end
            run(smh_pkg::SMH_OP_BLK_READ, 7'h5C, 8'h00, 8'h00, len[5:0], usePec);
            check_flag("read check error", corrupt, pecErr);
            check_byte("block length", len, 8'(got.size()));
            foreach (got[j]) begin
                check_byte("block byte", d, got[j]);
            end
            corrupt = 1'b0;
        end
        report_and_stop();
    end
endmodule // smh_master_tb
bind smh_master smh_master_props u_smh_master_props (.clk(clk), .resetn(resetn), .cmdValid(cmdValid), .cmd(cmd),
    .cmdReady(cmdReady), .rdData(rdData), .rdValid(rdValid), .done(done), .nackErr(nackErr), .pecErr(pecErr),
    .sclIn(sclIn), .sdaIn(sdaIn), .sclOut(sclOut), .sclOe(sclOe), .sdaOut(sdaOut), .sdaOe(sdaOe));
